// ### rtl/vtp_top.sv
// Purpose: Vector table placement with protected select change over APB.
// Assumes: Core signals are on sys_clk; fuses are mirrored in fuse_config.
// Notes: One APB wait state on every access; unmapped offsets answer pslverr.
//
// Behaviour
// - Select zero: flash start; one: boot start
// - Boot start derived from boot size fuses
// - Select writes ignored outside the enable window
// - Block interrupts from enable set until after
// - Unused enable blocks interrupts four cycles only
// - Global interrupt flag never altered by block
// - Enable clears after four cycles or select
// - Boot vectors, app lock: no application interrupts
// - App vectors, boot lock: no boot interrupts
// - Boot reset fuse with 2K: reset 0x1C00
// - Unprogrammed reset fuse, select set: reset zero
// - Relocated vector equals position plus boot start
//
// Design decisions made here: register access over APB and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module vtp_top
	import vtp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic irq_request,
	input wire logic [4:0] irq_number,
	input wire logic global_irq_enable,
	input wire logic instr_done,
	input wire logic [12:0] exec_pc,
	output logic irq_take,
	output logic [12:0] vector_address,
	output logic [12:0] reset_address
);

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Word-aligned address match
	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
		addr_is = (a[11:2] == off[11:2]);
	endfunction

	// First word of the boot section for a boot size fuse code
	function automatic logic [12:0] boot_start(input logic [1:0] sz);
		logic [12:0] words;
		words = VTP_BOOT_MIN_WORDS << (2'h3 - sz);
		boot_start = VTP_FLASH_LAST - words + 13'h0001;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	// Whole registered state of the block
	typedef struct packed
	{
		logic table_select;
		logic [4:0] fuses;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic take;
		logic [12:0] vec_addr;
		logic [12:0] rst_addr;
	} vtp_st_t;

	vtp_st_t cur; // Registered state
	vtp_st_t next_cur; // Next state

	logic access_done; // APB transfer completes on this edge
	logic ctl_write; // Write to mcu_control completes
	logic wr_change; // Written change enable bit
	logic change_enable; // Enable window open
	logic sel_accept; // Select write taken
	logic irq_hold; // Automatic hold, current
	logic next_irq_hold; // Automatic hold, next cycle
	logic [12:0] boot_base; // Boot section first word
	logic [12:0] vec_base; // Vector table base
	logic in_boot; // Core executes from the boot section
	logic lock_block; // Lock bits forbid interrupts here
	logic [31:0] read_word; // Read mux result
	logic read_hit; // Offset is mapped

	////////////////////////////////////////////////////////////////////////////
	// Bus strobes
	assign access_done = psel && penable && cur.ready;
	assign ctl_write = access_done && pwrite && addr_is(paddr, VTP_OFF_MCU_CONTROL);
	assign wr_change = pwdata[VTP_BIT_CHANGE_ENABLE];

	// Protected change sequence
	vtp_guard u_guard
	(
		.sys_clk(sys_clk),
		.srst(srst),
		.ctl_write(ctl_write),
		.wr_change(wr_change),
		.instr_done(instr_done),
		.change_enable(change_enable),
		.sel_accept(sel_accept),
		.irq_hold(irq_hold),
		.next_irq_hold(next_irq_hold)
	);

	////////////////////////////////////////////////////////////////////////////
	// Placement and lock decode
	always_comb
	begin
		boot_base = boot_start(cur.fuses[VTP_BIT_BOOT_SIZE_LO +: 2]);
		// Select picks flash start or boot start
		vec_base = cur.table_select ? boot_base : 13'h0000;
		in_boot = (exec_pc >= boot_base);
		// Programmed lock bit reads as zero
		lock_block = 1'b0;
		if (cur.table_select && !in_boot && !cur.fuses[VTP_BIT_APP_LOCK])
		begin
			lock_block = 1'b1;
		end
		if (!cur.table_select && in_boot && !cur.fuses[VTP_BIT_BOOT_LOCK])
		begin
			lock_block = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux
	always_comb
	begin
		read_word = 32'h0000_0000;
		read_hit = 1'b1;
		if (addr_is(paddr, VTP_OFF_MCU_CONTROL))
		begin
			// Enable reads back while the window is open
			read_word[VTP_BIT_CHANGE_ENABLE] = change_enable;
			read_word[VTP_BIT_TABLE_SELECT] = cur.table_select;
		end
		else if (addr_is(paddr, VTP_OFF_FUSE_CONFIG))
		begin
			read_word[4:0] = cur.fuses;
		end
		else if (addr_is(paddr, VTP_OFF_STATUS))
		begin
			read_word[VTP_BIT_ST_CHANGE] = change_enable;
			read_word[VTP_BIT_ST_HOLD] = irq_hold;
			read_word[VTP_BIT_ST_LOCK] = lock_block;
			read_word[VTP_BIT_ST_SELECT] = cur.table_select;
		end
		else if (addr_is(paddr, VTP_OFF_VECTORS))
		begin
			read_word[12:0] = vec_base;
			read_word[VTP_BIT_RESET_ADDR +: 13] = cur.rst_addr;
		end
		else
		begin
			// Unmapped offset
			read_hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		next_cur = cur;
		// APB: one wait state, then ready for a single cycle
		if (psel && penable && !cur.ready)
		begin
			next_cur.ready = 1'b1;
			next_cur.rdata = read_hit ? read_word : 32'h0000_0000;
			next_cur.err = !read_hit;
		end
		else
		begin
			next_cur.ready = 1'b0;
			next_cur.err = 1'b0;
		end
		// Select only moves when the guard accepts the write
		if (sel_accept)
		begin
			next_cur.table_select = pwdata[VTP_BIT_TABLE_SELECT];
		end
		// Fuse mirror is a plain read/write register
		if (access_done && pwrite && addr_is(paddr, VTP_OFF_FUSE_CONFIG))
		begin
			next_cur.fuses = pwdata[4:0];
		end
		// Vector of the pending request: position plus base
		next_cur.vec_addr = vec_base + {7'h00, irq_number, 1'b0};
		// Programmed boot reset fuse jumps to boot start
		if (!cur.fuses[VTP_BIT_BOOT_RESET])
		begin
			next_cur.rst_addr = boot_base;
		end
		else
		begin
			next_cur.rst_addr = 13'h0000;
		end
		// Gate only; the global flag is read, never written
		next_cur.take = irq_request && global_irq_enable && !next_irq_hold
			&& !lock_block;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			cur.table_select <= VTP_RST_SELECT;
			cur.fuses <= VTP_RST_FUSES;
			cur.rdata <= 32'h0000_0000;
			cur.ready <= 1'b0;
			cur.err <= 1'b0;
			cur.take <= 1'b0;
			cur.vec_addr <= 13'h0000;
			cur.rst_addr <= 13'h0000;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	// Outputs straight from flops
	assign prdata = cur.rdata;
	assign pready = cur.ready;
	assign pslverr = cur.err;
	assign irq_take = cur.take;
	assign vector_address = cur.vec_addr;
	assign reset_address = cur.rst_addr;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_sel_guarded;
		@(posedge sys_clk) disable iff (srst)
		!sel_accept |=> $stable(cur.table_select);
	endproperty
	a_sel_guarded: assert property (p_sel_guarded) else $error("select moved unguarded");

	property p_block_first;
		@(posedge sys_clk) disable iff (srst)
		(ctl_write && wr_change) |=> !irq_take;
	endproperty
	a_block_first: assert property (p_block_first) else $error("irq taken on enable set");

	property p_block_hold;
		@(posedge sys_clk) disable iff (srst)
		irq_hold |-> !irq_take;
	endproperty
	a_block_hold: assert property (p_block_hold) else $error("irq taken during hold");

	property p_vec_base;
		@(posedge sys_clk) disable iff (srst)
		!srst |=> (vector_address == ($past(vec_base) + {7'h00, $past(irq_number), 1'b0}));
	endproperty
	a_vec_base: assert property (p_vec_base) else $error("vector address wrong");

	property p_boot_2k;
		@(posedge sys_clk) disable iff (srst)
		(cur.fuses[2:0] == 3'h0) ##1 (cur.fuses[2:0] == 3'h0) |-> (reset_address == 13'h1C00);
	endproperty
	a_boot_2k: assert property (p_boot_2k) else $error("boot reset address wrong");

	property p_app_lock;
		@(posedge sys_clk) disable iff (srst)
		(cur.table_select && !in_boot && !cur.fuses[VTP_BIT_APP_LOCK]) |=> !irq_take;
	endproperty
	a_app_lock: assert property (p_app_lock) else $error("irq taken under app lock");

	property p_boot_lock;
		@(posedge sys_clk) disable iff (srst)
		(!cur.table_select && in_boot && !cur.fuses[VTP_BIT_BOOT_LOCK]) |=> !irq_take;
	endproperty
	a_boot_lock: assert property (p_boot_lock) else $error("irq taken under boot lock");

	property p_take_free;
		@(posedge sys_clk) disable iff (srst)
		(!srst && irq_request && global_irq_enable && !next_irq_hold && !lock_block) |=> irq_take;
	endproperty
	a_take_free: assert property (p_take_free) else $error("irq dropped while free");

	// Unprogrammed boot reset fuse always resets to flash start
	property p_app_reset;
		@(posedge sys_clk) disable iff (srst)
		(!srst && cur.fuses[VTP_BIT_BOOT_RESET]) |=> (reset_address == 13'h0000);
	endproperty
	a_app_reset: assert property (p_app_reset) else $error("reset address not zero");

	property p_apb_wait;
		@(posedge sys_clk) disable iff (srst)
		(psel && penable && !pready) |=> pready ##1 !pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb ready timing wrong");

endmodule

`default_nettype wire

// ### rtl/vtp_pkg.sv
// Purpose: Shared constants and types for the vector table placement block.
// Assumes: Word-addressed program flash, APB register access, one clock.
// Notes: Fuse bits follow the usual sense: zero means programmed.

package vtp_pkg;

	// Register byte offsets
	localparam logic [11:0] VTP_OFF_MCU_CONTROL = 12'h000;
	localparam logic [11:0] VTP_OFF_FUSE_CONFIG = 12'h004;
	localparam logic [11:0] VTP_OFF_STATUS = 12'h008;
	localparam logic [11:0] VTP_OFF_VECTORS = 12'h00C;

	// Field positions in mcu_control
	localparam int VTP_BIT_CHANGE_ENABLE = 0;
	localparam int VTP_BIT_TABLE_SELECT = 1;

	// Field positions in fuse_config
	localparam int VTP_BIT_BOOT_SIZE_LO = 0;
	localparam int VTP_BIT_BOOT_RESET = 2;
	localparam int VTP_BIT_APP_LOCK = 3;
	localparam int VTP_BIT_BOOT_LOCK = 4;

	// Field positions in status
	localparam int VTP_BIT_ST_CHANGE = 0;
	localparam int VTP_BIT_ST_HOLD = 1;
	localparam int VTP_BIT_ST_LOCK = 2;
	localparam int VTP_BIT_ST_SELECT = 3;

	// Field position of reset address in the vectors register
	localparam int VTP_BIT_RESET_ADDR = 16;

	// Reset values: select and change enable clear, fuses unprogrammed except boot size (code zero)
	localparam logic VTP_RST_SELECT = 1'b0;
	localparam logic [4:0] VTP_RST_FUSES = 5'h1C;

	// Flash geometry in words; smallest boot section in words
	localparam int VTP_PC_W = 13;
	localparam logic [12:0] VTP_FLASH_LAST = 13'h1FFF;
	localparam logic [12:0] VTP_BOOT_MIN_WORDS = 13'h0080;

	// Change enable stays open for this many clock cycles
	localparam int VTP_CE_WINDOW_CYCLES = 4;
	localparam logic [2:0] VTP_CE_LAST = 3'(VTP_CE_WINDOW_CYCLES - 1);

	// Guard sequence states
	typedef enum logic [1:0] {VTP_IDLE, VTP_ARMED, VTP_AFTER} vtp_gstate_t;

endpackage

// ### rtl/vtp_guard.sv
// Purpose: Change enable window and automatic interrupt hold.
// Assumes: ctl_write is a one-cycle pulse on the edge a control write lands.
// Notes: Hold outputs are combinational; the top registers them.

`timescale 1ns/1ps
`default_nettype none

module vtp_guard
	import vtp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ctl_write,
	input wire logic wr_change,
	input wire logic instr_done,
	output logic change_enable,
	output logic sel_accept,
	output logic irq_hold,
	output logic next_irq_hold
);

	// Whole state of the guard
	typedef struct packed
	{
		vtp_gstate_t state;
		logic [2:0] cnt;
	} vtp_gst_t;

	vtp_gst_t cur; // Registered state
	vtp_gst_t next_cur; // Next state

	////////////////////////////////////////////////////////////////////////////
	// Sequence logic
	always_comb
	begin
		next_cur = cur;
		sel_accept = 1'b0;
		case (cur.state)
			VTP_IDLE:
			begin
				// Arm on a write of the change enable bit
				if (ctl_write && wr_change)
				begin
					next_cur.state = VTP_ARMED;
					next_cur.cnt = VTP_CE_LAST;
				end
			end
			VTP_ARMED:
			begin
				if (ctl_write && !wr_change)
				begin
					// Select write inside the window, enable drops at once
					sel_accept = 1'b1;
					next_cur.state = VTP_AFTER;
				end
				else if (ctl_write && wr_change)
				begin
					// Rewriting the enable restarts the window
					next_cur.cnt = VTP_CE_LAST;
				end
				else if (cur.cnt == 3'h0)
				begin
					next_cur.state = VTP_IDLE;
				end
				else
				begin
					next_cur.cnt = cur.cnt - 3'h1;
				end
			end
			VTP_AFTER:
			begin
				// Hold until the following instruction has retired
				if (ctl_write && wr_change)
				begin
					next_cur.state = VTP_ARMED;
					next_cur.cnt = VTP_CE_LAST;
				end
				else if (instr_done)
				begin
					next_cur.state = VTP_IDLE;
				end
			end
			default:
			begin
				next_cur.state = VTP_IDLE;
			end
		endcase
	end

	// Flags seen by the top
	assign change_enable = (cur.state == VTP_ARMED);
	assign irq_hold = (cur.state != VTP_IDLE);
	// Next value lets the top block in the very cycle enable is set
	assign next_irq_hold = (next_cur.state != VTP_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			cur.state <= VTP_IDLE;
			cur.cnt <= 3'h0;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	// Window stays open through its fourth cycle when no write arrives
	property p_ce_open;
		@(posedge sys_clk) disable iff (srst)
		(!change_enable && ctl_write && wr_change) ##1 (!ctl_write)[*3]
			|-> change_enable ##1 change_enable;
	endproperty
	a_ce_open: assert property (p_ce_open) else $error("enable window too short");

	// Unused or consumed window is closed one cycle later
	property p_ce_close;
		@(posedge sys_clk) disable iff (srst)
		(!change_enable && ctl_write && wr_change) ##1 (!ctl_write)[*3]
			##1 !(ctl_write && wr_change) |=> !change_enable;
	endproperty
	a_ce_close: assert property (p_ce_close) else $error("enable outlived window");

	property p_ce_expire;
		@(posedge sys_clk) disable iff (srst)
		(!irq_hold && ctl_write && wr_change) ##1 (!ctl_write)[*4] |=> !irq_hold;
	endproperty
	a_ce_expire: assert property (p_ce_expire) else $error("hold outlived window");

	property p_accept_window;
		@(posedge sys_clk) disable iff (srst)
		sel_accept |-> change_enable ##1 (!change_enable && irq_hold);
	endproperty
	a_accept_window: assert property (p_accept_window) else $error("bad select accept");

endmodule

`default_nettype wire

// ### verification/vtp_core_model.sv
// Purpose: Core-side partner that retires instructions for the block.
// Assumes: Same clock as the block; run gates retirement.
// Notes: Gap sets the cycles between retirements, prompt or slow.

`timescale 1ns/1ps
`default_nettype none

module vtp_core_model
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [4:0] gap,
	output logic instr_done
);
	// Cycles since the last retirement
	logic [4:0] count;

	////////////////////////////////////////////////////////////////
	// One-cycle retirement pulse every gap plus one cycles while running
	always_ff @(posedge sys_clk)
	begin
		// Stopped core retires nothing, so a hold cannot end early
		if (srst || !run)
		begin
			count <= 5'h00;
			instr_done <= 1'b0;
		end
		else if (count >= gap)
		begin
			count <= 5'h00;
			instr_done <= 1'b1;
		end
		else
		begin
			count <= count + 5'h01;
			instr_done <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// ### verification/tb_vtp_top.sv
// Purpose: Self-checking bench for the vector table placement block.
// Assumes: One APB wait state; gate outputs registered, one cycle late.
// Notes: APB driven and sampled on rising edges; core outputs checked on falling edges.

`timescale 1ns/1ps
`default_nettype none

module tb_vtp_top
	import vtp_pkg::*;
;
	// Clock, reset and APB master side
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// Core side
	logic irq_request = 1'b0;
	logic [4:0] irq_number = 5'h00;
	logic global_irq_enable = 1'b0;
	logic [12:0] exec_pc = 13'h0000;
	logic instr_done;
	logic irq_take;
	logic [12:0] vector_address;
	logic [12:0] reset_address;
	logic run = 1'b0;
	logic [4:0] gap = 5'h03;
	// Counters and reference state
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	int m_sel = 0;
	int m_fuse = 32'h1C;
	logic [31:0] rd;
	logic er;

	always #20 sys_clk = ~sys_clk;

	vtp_top i_vtp_top (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_request(irq_request), .irq_number(irq_number),
		.global_irq_enable(global_irq_enable), .instr_done(instr_done), .exec_pc(exec_pc),
		.irq_take(irq_take), .vector_address(vector_address), .reset_address(reset_address));
	vtp_core_model i_vtp_core_model (.sys_clk(sys_clk), .srst(srst), .run(run), .gap(gap),
		.instr_done(instr_done));

	////////////////////////////////////////////////////////////////
	// Reference model: boot start, vectors, reset address, gate
	function automatic int bstart(int f);
		return 32'h2000 - (32'h80 << (3 - (f & 3)));
	endfunction
	function automatic int vexp(int k);
		return (m_sel != 0 ? bstart(m_fuse) : 0) + 2 * k;
	endfunction
	function automatic int rexp();
		return m_fuse[2] ? 0 : bstart(m_fuse);
	endfunction
	function automatic int lexp();
		int bs;
		int lk;
		bs = bstart(m_fuse);
		lk = m_sel != 0 ? (!m_fuse[3] && exec_pc < bs) : (!m_fuse[4] && exec_pc >= bs);
		return irq_request && global_irq_enable && !lk;
	endfunction

	////////////////////////////////////////////////////////////////
	// Compare, bus and gate tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, w, seen, exp);
		end
	endtask
	// Request held until the edge that samples pready high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Ready and read data are taken at the same rising edge
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
	endtask
	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		idle();
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string w);
		apb(1'b0, a, 32'h0);
		idle();
		chk(rd, exp, w);
		chk(er, a > 12'h00C, "error flag");
	endtask
	// Back to back: select write lands three cycles after enable
	task automatic seq(input int s);
		apb(1'b1, VTP_OFF_MCU_CONTROL, 32'h1);
		apb(1'b1, VTP_OFF_MCU_CONTROL, 32'(s << 1));
		idle();
		m_sel = s;
	endtask
	task automatic gate(input logic [12:0] pc, input logic [4:0] k);
		exec_pc <= pc;
		irq_number <= k;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(irq_take, lexp(), "take");
		chk(vector_address, vexp(k), "vector");
		chk(reset_address, rexp(), "reset address");
		@(posedge sys_clk);
	endtask
	task automatic hold0(input int c);
		repeat (c)
		begin
			@(negedge sys_clk);
			chk(irq_take, 1'b0, "held");
			@(posedge sys_clk);
		end
	endtask
	task automatic wait_take(input int lim, input string w);
		int k;
		k = 0;
		do
		begin
			@(negedge sys_clk);
			k++;
		end
		while (irq_take !== 1'b1 && k < lim);
		chk(irq_take, 1'b1, w);
		@(posedge sys_clk);
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard: the whole run needs about two hundred and fifty cycles
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		void'($urandom(2));
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rdc(VTP_OFF_MCU_CONTROL, 32'h0, "control reset");
		rdc(VTP_OFF_FUSE_CONFIG, 32'h1C, "fuse reset");
		rdc(VTP_OFF_VECTORS, 32'h0, "vectors reset");
		rdc(12'h010, 32'h0, "unmapped read");
		$display("test reset done");
		// Core flag owned by the core; the block only reads it
		irq_request <= 1'b1;
		global_irq_enable <= 1'b1;
		wr(VTP_OFF_MCU_CONTROL, 32'h2);
		rdc(VTP_OFF_MCU_CONTROL, 32'h0, "unarmed select");
		gate(13'($urandom % 32'h1C00), 5'(1 + $urandom % 25));
		// Bus released at the landing edge so all four held cycles are watched
		apb(1'b1, VTP_OFF_MCU_CONTROL, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		hold0(4);
		wait_take(1, "window end");
		wr(VTP_OFF_MCU_CONTROL, 32'h1);
		repeat (4) @(posedge sys_clk);
		rdc(VTP_OFF_MCU_CONTROL, 32'h0, "enable self clear");
		wr(VTP_OFF_MCU_CONTROL, 32'h2);
		rdc(VTP_OFF_MCU_CONTROL, 32'h0, "late select");
		$display("test window done");
		// Stopped core: hold must outlast the consumed window
		seq(1);
		hold0(6);
		// Hold and select set, window closed, no lock
		rdc(VTP_OFF_STATUS, 32'h0000_000A, "status in hold");
		run <= 1'b1;
		wait_take(12, "hold end");
		rdc(VTP_OFF_MCU_CONTROL, 32'h2, "select set");
		rdc(VTP_OFF_VECTORS, 32'h1C00, "boot base");
		$display("test select done");
		m_fuse = 32'h14;
		wr(VTP_OFF_FUSE_CONFIG, 32'h14);
		gate(13'($urandom % 32'h1C00), 5'(1 + $urandom % 25));
		gate(13'(32'h1C00 + $urandom % 32'h400), 5'h01);
		seq(0);
		repeat (8) @(posedge sys_clk);
		m_fuse = 32'h0C;
		wr(VTP_OFF_FUSE_CONFIG, 32'h0C);
		gate(13'(32'h1C00 + $urandom % 32'h400), 5'(1 + $urandom % 25));
		gate(13'($urandom % 32'h1C00), 5'h19);
		global_irq_enable <= 1'b0;
		gate(13'h0000, 5'h02);
		global_irq_enable <= 1'b1;
		$display("test lock done");
		seq(1);
		repeat (8) @(posedge sys_clk);
		for (int s = 0; s < 8; s++)
		begin
			m_fuse = 32'h18 | s;
			wr(VTP_OFF_FUSE_CONFIG, 32'(m_fuse));
			rdc(VTP_OFF_VECTORS, 32'((rexp() << 16) | bstart(m_fuse)), "vectors");
			gate(13'(bstart(m_fuse) + $urandom % 32'h80), 5'(1 + $urandom % 25));
		end
		$display("test sizes done");
		// Mid-run reset must bring the vectors back to flash start
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		m_sel = 0;
		m_fuse = 32'h1C;
		@(posedge sys_clk);
		rdc(VTP_OFF_MCU_CONTROL, 32'h0, "control after reset");
		rdc(VTP_OFF_FUSE_CONFIG, 32'h1C, "fuse after reset");
		gate(13'h1F00, 5'h04);
		$display("test second reset done");
		print_verdict();
	end
endmodule

`default_nettype wire
